// *** hdl/dual_parallel_port_control.sv ***
`timescale 1ns/10ps
`default_nettype none
module dual_parallel_port_control (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // processor bus strobes and selects
  input wire logic enable_strobe_i,
  input wire logic chip_select_0_i,
  input wire logic chip_select_1_i,
  input wire logic chip_select_2_n_i,
  input wire logic reg_select_low_i,
  input wire logic reg_select_high_i,
  input wire logic read_not_write_i,
  // processor data bus, three signals of a two-way pin
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // section a peripheral lines
  input wire logic [7:0] port_a_lines_i,
  output logic [7:0] port_a_lines_o,
  output logic [7:0] port_a_lines_oe_o,
  input wire logic a_irq_input_i,
  input wire logic a_dual_control_line_i,
  output logic a_dual_control_line_o,
  output logic a_dual_control_line_oe_o,
  // section b peripheral lines
  input wire logic [7:0] port_b_lines_i,
  output logic [7:0] port_b_lines_o,
  output logic [7:0] port_b_lines_oe_o,
  input wire logic b_irq_input_i,
  input wire logic b_dual_control_line_i,
  output logic b_dual_control_line_o,
  output logic b_dual_control_line_oe_o,
  // open-drain interrupt requests: level, and enable that pulls low
  output logic a_interrupt_request_n_o,
  output logic a_interrupt_request_oe_o,
  output logic b_interrupt_request_n_o,
  output logic b_interrupt_request_oe_o
);

  // ******************************************************************
  // bus pin synchronisers
  // ******************************************************************

  // all bus pins are asynchronous to clock_i; stage one feeds stage two only
  logic [6:0] bus_meta_reg;
  logic [6:0] bus_sync_reg;
  logic [7:0] din_meta_reg;
  logic [7:0] din_sync_reg;
  logic strobe_last_reg;

  // strobe, selects and direction travel together through two stages
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      bus_meta_reg <= 7'h00;
      bus_sync_reg <= 7'h00;
    end else begin
      bus_meta_reg <= {enable_strobe_i, chip_select_0_i, chip_select_1_i, chip_select_2_n_i,
                       reg_select_high_i, reg_select_low_i, read_not_write_i};
      bus_sync_reg <= bus_meta_reg;
    end
  end

  // write data is used only at a strobe fall, long after it has settled
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      din_meta_reg <= 8'h00;
      din_sync_reg <= 8'h00;
    end else begin
      din_meta_reg <= data_i;
      din_sync_reg <= din_meta_reg;
    end
  end

  // strobe history; resets low like an idle strobe, so no false fall
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      strobe_last_reg <= 1'b0;
    end else begin
      strobe_last_reg <= bus_sync_reg[6];
    end
  end

  // ******************************************************************
  // bus decode
  // ******************************************************************

  // decoded bus terms, all from the second synchroniser stage
  wire strobe_high = bus_sync_reg[6];
  wire chip_selected = bus_sync_reg[5] & bus_sync_reg[4] & ~bus_sync_reg[3];
  wire [1:0] sel_code = bus_sync_reg[2:1];
  wire is_read = bus_sync_reg[0];
  // access acts on the trailing edge of the strobe, when selects are settled
  wire strobe_fall = strobe_last_reg & ~strobe_high;
  wire access_end = strobe_fall & chip_selected;
  wire write_end = access_end & ~is_read;
  wire read_end = access_end & is_read;
  // section chosen by the high select bit, control chosen by the low one
  wire sel_section = sel_code[1];
  wire sel_control = sel_code[0];

  // ******************************************************************
  // port pin synchronisers
  // ******************************************************************

  // port lines are sampled every clock; a read shows them three clocks late
  logic [7:0] pin_meta_reg [dual_port_pkg::SECTIONS];
  logic [7:0] pin_sync_reg [dual_port_pkg::SECTIONS];

  // ******************************************************************
  // per-section register state, read back and outputs
  // ******************************************************************

  logic [7:0] out_reg [dual_port_pkg::SECTIONS];
  logic [7:0] dir_reg [dual_port_pkg::SECTIONS];
  logic [5:0] ctl_reg [dual_port_pkg::SECTIONS];
  logic edge_flag_reg [dual_port_pkg::SECTIONS];
  logic dual_flag_reg [dual_port_pkg::SECTIONS];
  logic irq_n_reg [dual_port_pkg::SECTIONS];
  logic irq_oe_reg [dual_port_pkg::SECTIONS];
  logic dual_out_reg [dual_port_pkg::SECTIONS];
  logic dual_oe_reg [dual_port_pkg::SECTIONS];
  logic [7:0] data_view [dual_port_pkg::SECTIONS];
  logic [7:0] ctl_view [dual_port_pkg::SECTIONS];
  wire [7:0] port_pins [dual_port_pkg::SECTIONS];
  wire irq_pins [dual_port_pkg::SECTIONS];
  wire dual_pins [dual_port_pkg::SECTIONS];

  assign port_pins[0] = port_a_lines_i;
  assign port_pins[1] = port_b_lines_i;
  assign irq_pins[0] = a_irq_input_i;
  assign irq_pins[1] = b_irq_input_i;
  assign dual_pins[0] = a_dual_control_line_i;
  assign dual_pins[1] = b_dual_control_line_i;

  genvar s;
  generate
    for (s = 0; s < dual_port_pkg::SECTIONS; s = s + 1) begin : g_section
      logic irq_rise;
      logic irq_fall;
      logic dual_rise;
      logic dual_fall;

      // edge sensing on the interrupt-only input
      pin_edge_sync u_irq_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(irq_pins[s]),
        .level_o(),
        .rise_o(irq_rise),
        .fall_o(irq_fall)
      );

      // edge sensing on the dual-purpose line, even while it is an output
      pin_edge_sync u_dual_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(dual_pins[s]),
        .level_o(),
        .rise_o(dual_rise),
        .fall_o(dual_fall)
      );

      // section hit terms
      wire this_section = (sel_section == 1'(s));
      wire data_selected = ctl_reg[s][dual_port_pkg::CTL_DATA_SEL_BIT];
      wire wr_ctl = write_end & this_section & sel_control;
      wire wr_data = write_end & this_section & ~sel_control & data_selected;
      wire wr_dir = write_end & this_section & ~sel_control & ~data_selected;
      wire rd_data = read_end & this_section & ~sel_control & data_selected;

      // flag set terms: edge polarity chosen by bits 1 and 4
      wire edge_set = ctl_reg[s][dual_port_pkg::CTL_EDGE_POL_BIT] ? irq_rise : irq_fall;
      wire dual_is_out = ctl_reg[s][dual_port_pkg::CTL_DUAL_OUT_BIT];
      wire dual_edge = ctl_reg[s][dual_port_pkg::CTL_DUAL_POL_BIT] ? dual_rise : dual_fall;
      wire dual_set = ~dual_is_out & dual_edge;

      // request term from both enabled flags
      wire edge_req = edge_flag_reg[s] & ctl_reg[s][dual_port_pkg::CTL_IRQ_EN_BIT];
      wire dual_req = dual_flag_reg[s] & ctl_reg[s][dual_port_pkg::CTL_DUAL_EN_BIT] & ~dual_is_out;
      wire req_next = edge_req | dual_req;

      // pin synchroniser for the 8 port lines
      always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
          pin_meta_reg[s] <= 8'h00;
          pin_sync_reg[s] <= 8'h00;
        end else begin
          pin_meta_reg[s] <= port_pins[s];
          pin_sync_reg[s] <= pin_meta_reg[s];
        end
      end

      // data register; a read of it clears both flags
      always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
          out_reg[s] <= dual_port_pkg::DATA_RESET;
        end else if (wr_data) begin
          out_reg[s] <= din_sync_reg;
        end
      end

      // direction register, zero after reset so every line starts as input
      always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
          dir_reg[s] <= dual_port_pkg::DIR_RESET;
        end else if (wr_dir) begin
          dir_reg[s] <= din_sync_reg;
        end
      end

      // control register: only the six writable bits are stored
      always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
          ctl_reg[s] <= dual_port_pkg::CTL_RESET;
        end else if (wr_ctl) begin
          ctl_reg[s] <= din_sync_reg[5:0];
        end
      end

      // edge flag: an edge in the clearing cycle wins, so no event is lost
      always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
          edge_flag_reg[s] <= dual_port_pkg::FLAG_RESET;
        end else begin
          edge_flag_reg[s] <= edge_set | (edge_flag_reg[s] & ~rd_data);
        end
      end

      // dual line flag, held clear while the line is an output
      always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
          dual_flag_reg[s] <= dual_port_pkg::FLAG_RESET;
        end else begin
          dual_flag_reg[s] <= ~dual_is_out & (dual_set | (dual_flag_reg[s] & ~rd_data));
        end
      end

      // request follows the flags, so a late enable still raises it;
      // the pull enable has its own flop, so the open-drain pin never glitches
      always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
          irq_n_reg[s] <= dual_port_pkg::IRQ_N_RESET;
          irq_oe_reg[s] <= ~dual_port_pkg::IRQ_N_RESET;
        end else begin
          irq_n_reg[s] <= ~req_next;
          irq_oe_reg[s] <= req_next;
        end
      end

      // dual line as a static level; the handshake modes are not built
      always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
          dual_out_reg[s] <= 1'b0;
        end else begin
          dual_out_reg[s] <= ctl_reg[s][dual_port_pkg::CTL_DUAL_EN_BIT];
        end
      end

      // dual line drive enable follows control bit 5
      always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
          dual_oe_reg[s] <= 1'b0;
        end else begin
          dual_oe_reg[s] <= dual_is_out;
        end
      end

      // read views: inputs show the pin, outputs show the stored value
      assign data_view[s] = (dir_reg[s] & out_reg[s]) | (~dir_reg[s] & pin_sync_reg[s]);
      assign ctl_view[s] = {edge_flag_reg[s], dual_flag_reg[s], ctl_reg[s]};
    end
  endgenerate

  // ******************************************************************
  // read multiplexer and bus drive
  // ******************************************************************

  // pick one of the six locations from select code and data-select bit
  wire sec_data_sel = ctl_reg[sel_section][dual_port_pkg::CTL_DATA_SEL_BIT];
  wire [7:0] sec_data_dir = sec_data_sel ? data_view[sel_section] : dir_reg[sel_section];
  wire [7:0] read_mux = sel_control ? ctl_view[sel_section] : sec_data_dir;
  // drive only while a selected read strobe is high
  wire drive_next = strobe_high & chip_selected & is_read;

  logic [7:0] data_out_reg;
  logic data_oe_reg;

  // read data is refreshed every cycle so it tracks pins during the strobe
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      data_out_reg <= dual_port_pkg::DATA_RESET;
    end else begin
      data_out_reg <= read_mux;
    end
  end

  // bus drive lags the strobe by the synchroniser, three clocks each way
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      data_oe_reg <= 1'b0;
    end else begin
      data_oe_reg <= drive_next;
    end
  end

  // ******************************************************************
  // output hookup, every output straight from a flop
  // ******************************************************************

  assign data_o = data_out_reg;
  assign data_oe_o = data_oe_reg;
  assign port_a_lines_o = out_reg[0];
  assign port_a_lines_oe_o = dir_reg[0];
  assign port_b_lines_o = out_reg[1];
  assign port_b_lines_oe_o = dir_reg[1];
  assign a_dual_control_line_o = dual_out_reg[0];
  assign a_dual_control_line_oe_o = dual_oe_reg[0];
  assign b_dual_control_line_o = dual_out_reg[1];
  assign b_dual_control_line_oe_o = dual_oe_reg[1];
  // open drain: the enable pulls the wire low while a request stands
  assign a_interrupt_request_n_o = irq_n_reg[0];
  assign a_interrupt_request_oe_o = irq_oe_reg[0];
  assign b_interrupt_request_n_o = irq_n_reg[1];
  assign b_interrupt_request_oe_o = irq_oe_reg[1];

endmodule
`default_nettype wire

// *** shared/dual_port_pkg.sv ***
// ********************************************************************
// constants shared by the dual parallel port control block
// ********************************************************************
package dual_port_pkg;

  // ******************************************************************
  // widths and section count
  // ******************************************************************
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SECTIONS = 2;
  localparam int unsigned CTL_RW_W = 6;

  // ******************************************************************
  // values after reset: all zero except the request level, so all lines are inputs
  // ******************************************************************
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [5:0] CTL_RESET = 6'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic IRQ_N_RESET = 1'b1;

  // ******************************************************************
  // control register field positions
  // ******************************************************************
  localparam int unsigned CTL_IRQ_EN_BIT = 0;     // edge flag request enable
  localparam int unsigned CTL_EDGE_POL_BIT = 1;   // 1 = rising edge on irq input
  localparam int unsigned CTL_DATA_SEL_BIT = 2;   // 1 = data, 0 = direction
  localparam int unsigned CTL_DUAL_EN_BIT = 3;    // dual flag enable / static level
  localparam int unsigned CTL_DUAL_POL_BIT = 4;   // 1 = rising edge on dual line
  localparam int unsigned CTL_DUAL_OUT_BIT = 5;   // 1 = dual line is an output
  localparam int unsigned CTL_DUAL_FLAG_BIT = 6;
  localparam int unsigned CTL_EDGE_FLAG_BIT = 7;

  // ******************************************************************
  // select codes {reg_select_high, reg_select_low}
  // ******************************************************************
  localparam logic [1:0] SEL_A_DATA_DIR = 2'h0;
  localparam logic [1:0] SEL_A_CONTROL = 2'h1;
  localparam logic [1:0] SEL_B_DATA_DIR = 2'h2;
  localparam logic [1:0] SEL_B_CONTROL = 2'h3;

  // ******************************************************************
  // synchroniser depth for pins
  // ******************************************************************
  localparam int unsigned SYNC_STAGES = 2;

endpackage

// *** hdl/pin_edge_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// two-stage synchroniser with edge detection for one control pin
// ********************************************************************
module pin_edge_sync (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // pin side
  input wire logic pin_i,
  // synchronised results
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic meta_reg;
  logic level_reg;
  logic last_reg;
  logic [2:0] armed_reg;

  // first flop feeds only the second; edges come from stages two and three
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      meta_reg <= 1'b0;
      level_reg <= 1'b0;
      last_reg <= 1'b0;
      armed_reg <= 3'h0;
    end else begin
      meta_reg <= pin_i;
      level_reg <= meta_reg;
      last_reg <= level_reg;
      armed_reg <= {armed_reg[1:0], 1'b1};
    end
  end

  // edges are one-cycle pulses; held off until stage three holds a real
  // pin level, so a pin idling high gives no false rise after reset
  assign level_o = level_reg;
  assign rise_o = armed_reg[2] & level_reg & ~last_reg;
  assign fall_o = armed_reg[2] & ~level_reg & last_reg;

endmodule
`default_nettype wire

// *** bench/dual_port_checker_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********
// pin level checks of the port block
// ********
module dual_port_checker (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // processor bus
  input wire logic enable_strobe_i,
  input wire logic chip_select_0_i,
  input wire logic chip_select_1_i,
  input wire logic chip_select_2_n_i,
  input wire logic reg_select_low_i,
  input wire logic reg_select_high_i,
  input wire logic read_not_write_i,
  input wire logic data_oe_o,
  // peripheral side
  input wire logic [7:0] port_a_lines_o,
  input wire logic [7:0] port_a_lines_oe_o,
  input wire logic [7:0] port_b_lines_o,
  input wire logic [7:0] port_b_lines_oe_o,
  input wire logic a_dual_control_line_o,
  input wire logic a_dual_control_line_oe_o,
  input wire logic b_dual_control_line_o,
  input wire logic b_dual_control_line_oe_o,
  input wire logic a_interrupt_request_n_o,
  input wire logic a_interrupt_request_oe_o,
  input wire logic b_interrupt_request_n_o,
  input wire logic b_interrupt_request_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // write decodes from raw pins; selects are held past the strobe fall, so the edge before an update still shows them
  wire sel_w = chip_select_0_i && chip_select_1_i && !chip_select_2_n_i && !read_not_write_i;
  wire wr_a = sel_w && !reg_select_high_i && !reg_select_low_i;
  wire wr_b = sel_w && reg_select_high_i && !reg_select_low_i;
  wire wc_a = sel_w && !reg_select_high_i && reg_select_low_i;
  wire wc_b = sel_w && reg_select_high_i && reg_select_low_i;
  AST_RESET_CLEAR: assert property ($past(sys_rst_i) |->
    port_a_lines_oe_o == 8'h00 && port_b_lines_oe_o == 8'h00 && !data_oe_o && a_interrupt_request_n_o
    && b_interrupt_request_n_o) else $error("outputs not cleared by reset");
  AST_A_REQ_OE: assert property (a_interrupt_request_oe_o == !a_interrupt_request_n_o)
    else $error("request a pull disagrees with level");
  AST_B_REQ_OE: assert property (b_interrupt_request_oe_o == !b_interrupt_request_n_o)
    else $error("request b pull disagrees with level");
  AST_READ_OE_CAUSE: assert property ($rose(data_oe_o) |-> $past(enable_strobe_i, 3)
    && $past(read_not_write_i, 3) && $past(chip_select_0_i, 3)) else $error("bus driven without a read");
  AST_READ_OE_DROP: assert property ($fell(enable_strobe_i) |-> ##[2:5] !data_oe_o)
    else $error("bus still driven after strobe");
  AST_A_PORT_WRITE: assert property ($changed(port_a_lines_o) || $changed(port_a_lines_oe_o) |-> $past(wr_a))
    else $error("port a changed without a write");
  AST_B_PORT_WRITE: assert property ($changed(port_b_lines_o) || $changed(port_b_lines_oe_o) |-> $past(wr_b))
    else $error("port b changed without a write");
  AST_A_DUAL_WRITE: assert property ($changed(a_dual_control_line_o) ||
    $changed(a_dual_control_line_oe_o) |-> $past(wc_a)) else $error("dual line a changed without a write");
  AST_B_DUAL_WRITE: assert property ($changed(b_dual_control_line_o) ||
    $changed(b_dual_control_line_oe_o) |-> $past(wc_b)) else $error("dual line b changed without a write");
  // main scenarios reached
  cover property ($rose(data_oe_o));
  cover property ($fell(a_interrupt_request_n_o));
  cover property ($fell(b_interrupt_request_n_o));
endmodule
bind dual_parallel_port_control dual_port_checker i_dual_port_checker (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .enable_strobe_i(enable_strobe_i), .chip_select_0_i(chip_select_0_i), .chip_select_1_i(chip_select_1_i),
  .chip_select_2_n_i(chip_select_2_n_i), .reg_select_low_i(reg_select_low_i), .reg_select_high_i(reg_select_high_i),
  .read_not_write_i(read_not_write_i), .data_oe_o(data_oe_o), .port_a_lines_o(port_a_lines_o),
  .port_a_lines_oe_o(port_a_lines_oe_o), .port_b_lines_o(port_b_lines_o), .port_b_lines_oe_o(port_b_lines_oe_o),
  .a_dual_control_line_o(a_dual_control_line_o), .a_dual_control_line_oe_o(a_dual_control_line_oe_o),
  .b_dual_control_line_o(b_dual_control_line_o), .b_dual_control_line_oe_o(b_dual_control_line_oe_o),
  .a_interrupt_request_n_o(a_interrupt_request_n_o), .a_interrupt_request_oe_o(a_interrupt_request_oe_o),
  .b_interrupt_request_n_o(b_interrupt_request_n_o), .b_interrupt_request_oe_o(b_interrupt_request_oe_o));
`default_nettype wire

// *** bench/peripheral_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********
// peripheral device: drives each line wherever the block does not
// ********
module peripheral_model (
  // block drive
  input wire logic [7:0] a_out_i,
  input wire logic [7:0] a_oe_i,
  input wire logic [7:0] b_out_i,
  input wire logic [7:0] b_oe_i,
  input wire logic [1:0] dual_out_i,
  input wire logic [1:0] dual_oe_i,
  // peripheral levels
  input wire logic [7:0] a_drv_i,
  input wire logic [7:0] b_drv_i,
  input wire logic [1:0] dual_drv_i,
  // resolved wires
  output logic [7:0] a_pin_o,
  output logic [7:0] b_pin_o,
  output logic [1:0] dual_pin_o
);
  // bitwise resolution, so a half output port still reads the peripheral on its input bits
  assign a_pin_o = (a_out_i & a_oe_i) | (a_drv_i & ~a_oe_i);
  assign b_pin_o = (b_out_i & b_oe_i) | (b_drv_i & ~b_oe_i);
  assign dual_pin_o = (dual_out_i & dual_oe_i) | (dual_drv_i & ~dual_oe_i);
endmodule
`default_nettype wire

// *** bench/test_dual_parallel_port_control.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********
// bench for the dual parallel port control block
// ********
module test_dual_parallel_port_control;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic strobe = 1'b0;
  logic cs0 = 1'b0;
  logic rs_hi = 1'b0;
  logic rs_lo = 1'b0;
  logic rnw = 1'b1;
  logic [7:0] dbus = 8'h00;
  logic [7:0] data_mem [2];
  logic [7:0] dir_mem [2];
  logic [7:0] drv [2];
  logic [1:0] irq_pin = 2'h0;
  logic [1:0] dual_drv = 2'h0;
  logic [31:0] seed = 32'h11;
  logic [7:0] exp_q [$];
  logic oe_seen = 1'b0;
  int bad_count = 0;
  int n_tests = 0;
  wire logic [7:0] data_o, pa_o, pa_oe, pb_o, pb_oe, pa_pin, pb_pin;
  wire logic data_oe, a_n, a_oe, b_n, b_oe;
  wire logic [1:0] dual_o, dual_oe, dual_pin;
  // free running clock
  always #5 clock_i = ~clock_i;
  dual_parallel_port_control i_dual_parallel_port_control (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .enable_strobe_i(strobe), .chip_select_0_i(cs0), .chip_select_1_i(1'b1), .chip_select_2_n_i(1'b0),
    .reg_select_low_i(rs_lo), .reg_select_high_i(rs_hi), .read_not_write_i(rnw), .data_i(dbus),
    .data_o(data_o), .data_oe_o(data_oe), .port_a_lines_i(pa_pin), .port_a_lines_o(pa_o), .port_a_lines_oe_o(pa_oe),
    .a_irq_input_i(irq_pin[0]), .a_dual_control_line_i(dual_pin[0]), .a_dual_control_line_o(dual_o[0]),
    .a_dual_control_line_oe_o(dual_oe[0]), .port_b_lines_i(pb_pin), .port_b_lines_o(pb_o), .port_b_lines_oe_o(pb_oe),
    .b_irq_input_i(irq_pin[1]), .b_dual_control_line_i(dual_pin[1]), .b_dual_control_line_o(dual_o[1]),
    .b_dual_control_line_oe_o(dual_oe[1]), .a_interrupt_request_n_o(a_n), .a_interrupt_request_oe_o(a_oe),
    .b_interrupt_request_n_o(b_n), .b_interrupt_request_oe_o(b_oe));
  peripheral_model i_peripheral_model (.a_out_i(pa_o), .a_oe_i(pa_oe), .b_out_i(pb_o), .b_oe_i(pb_oe),
    .dual_out_i(dual_o), .dual_oe_i(dual_oe), .a_drv_i(drv[0]), .b_drv_i(drv[1]), .dual_drv_i(dual_drv),
    .a_pin_o(pa_pin), .b_pin_o(pb_pin), .dual_pin_o(dual_pin));
  // xorshift source, seeded at 17
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one access: strobe high six cycles, selects held five cycles past the fall as the block needs
  task automatic bus(input logic [1:0] sel, input logic rd, input logic [7:0] wv, input logic [7:0] ev);
    if (rd) exp_q.push_back(ev);
    @(negedge clock_i);
    {rs_hi, rs_lo} = sel;
    rnw = rd;
    dbus = wv;
    cs0 = 1'b1;
    strobe = 1'b1;
    repeat (6) @(negedge clock_i);
    strobe = 1'b0;
    repeat (5) @(negedge clock_i);
    cs0 = 1'b0;
    rnw = 1'b1;
  endtask
  function automatic logic [7:0] pexp(input int s);
    return (data_mem[s] & dir_mem[s]) | (drv[s] & ~dir_mem[s]);
  endfunction
  task automatic irq_chk(input int s, input logic e);
    repeat (3) @(negedge clock_i);
    check("request", {6'h0, !e, e}, s ? {6'h0, b_oe, b_n} : {6'h0, a_oe, a_n});
  endtask
  // k picks the edge input or the dual line; pin levels are held for one data read between edges
  task automatic edge_case(input int s, input logic k, input logic pol);
    logic [7:0] cfg, en;
    cfg = k ? {3'h0, pol, 4'h4} : {6'h1, pol, 1'b0};
    en = k ? 8'h08 : 8'h01;
    bus({s[0], 1'b1}, 1'b0, cfg, 8'h00);
    if (k) dual_drv[s] = !pol; else irq_pin[s] = !pol;
    repeat (6) @(negedge clock_i);
    bus({s[0], 1'b0}, 1'b1, 8'h00, pexp(s));
    if (k) dual_drv[s] = pol; else irq_pin[s] = pol;
    repeat (6) @(negedge clock_i);
    irq_chk(s, 1'b1);
    bus({s[0], 1'b1}, 1'b1, 8'h00, cfg | (k ? 8'h40 : 8'h80));
    bus({s[0], 1'b1}, 1'b0, cfg | en, 8'h00);
    irq_chk(s, 1'b0);
    bus({s[0], 1'b0}, 1'b1, 8'h00, pexp(s));
    irq_chk(s, 1'b1);
    bus({s[0], 1'b1}, 1'b1, 8'h00, cfg | en);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // read checker: takes the oldest note when the block starts driving the bus
  always @(negedge clock_i) begin
    if (data_oe === 1'b1 && !oe_seen) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("Error read data expected none seen %h", data_o);
      end else check("read data", exp_q.pop_front(), data_o);
    end
    oe_seen = (data_oe === 1'b1);
  end
  // watchdog, well beyond the thousand or so cycles the tests take
  initial begin
    repeat (30000) @(posedge clock_i);
    bad_count++;
    $display("Error watchdog expected finish seen timeout");
    close_out();
  end
  // main sequence
  initial begin
    drv[0] = 8'h00;
    drv[1] = 8'h00;
    repeat (10) @(negedge clock_i);
    sys_rst_i = 1'b0;
    for (int s = 0; s < 2; s++) begin
      bus({s[0], 1'b1}, 1'b1, 8'h00, 8'h00);
      bus({s[0], 1'b0}, 1'b1, 8'h00, 8'h00);
      irq_chk(s, 1'b1);
      dir_mem[s] = rnd();
      data_mem[s] = rnd();
      drv[s] = rnd();
      bus({s[0], 1'b0}, 1'b0, dir_mem[s], 8'h00);
      bus({s[0], 1'b0}, 1'b1, 8'h00, dir_mem[s]);
      bus({s[0], 1'b1}, 1'b0, 8'h04, 8'h00);
      bus({s[0], 1'b0}, 1'b0, data_mem[s], 8'h00);
      check("port enable", dir_mem[s], s ? pb_oe : pa_oe);
      check("port out", data_mem[s], s ? pb_o : pa_o);
      bus({s[0], 1'b0}, 1'b1, 8'h00, pexp(s));
      bus({s[0], 1'b1}, 1'b0, 8'hff, 8'h00);
      bus({s[0], 1'b1}, 1'b1, 8'h00, 8'h3f);
      check("dual line", 8'h03, {6'h0, dual_oe[s], dual_o[s]});
      $display("section %0d registers done", s);
    end
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 4; k++) begin
        edge_case(s, k[1], k[0]);
      end
      $display("section %0d interrupts done", s);
    end
    close_out();
  end
endmodule
`default_nettype wire
